//--- verif/amp_power_fault_control_test.sv
// Purpose: Self-checking bench of the amplifier power and fault controller
// Assumes: Host model drives the pins; bench drives AHB-Lite and detectors
// Notes:   Read data is checked from a queue by a bus monitor
`timescale 1ns/1ps
`include "apfc_regs.svh"

module amp_power_fault_control_test;
   logic        clock, srst, hsel, hwrite, hready, hreadyout, hresp;
   logic        carrier_tick, fault_o, fault_oe, rd_dph, vchk;
   logic        rst_req, sleep_req, pll_on, def_hi, mclk_stop, abuse;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  det;
   logic [7:0]  volume_level, vol_p;
   logic [10:0] mclk_ratio;
   logic [31:0] haddr, hwdata, hrdata, seed;
   logic [63:0] exp_q[$];
   int          err_count, cmp_count, tmo;
   apfc_pkg::apfc_pins_t pins;
   apfc_pkg::apfc_ctl_t  ctl;

   apfc_host_model i_host (.clock(clock), .rst_req(rst_req), .sleep_req(sleep_req),
      .pll_on(pll_on), .def_hi(def_hi), .mclk_stop(mclk_stop), .abuse(abuse),
      .det(det), .pins(pins));
   apfc_ctrl i_dut (.clock(clock), .srst(srst), .pins(pins), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ctl(ctl),
      .volume_level(volume_level), .carrier_tick(carrier_tick),
      .mclk_ratio(mclk_ratio), .fault_o(fault_o), .fault_oe(fault_oe));

   assign hready = hreadyout;

   initial begin
      clock = 1'b0;
      forever #12.5 clock = !clock;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task finish_test;
      if (err_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      do @(posedge clock); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hready !== 1'b1);
   endtask

   task wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back({e & m, m});
      bus(1'b0, a, 32'h0);
   endtask

   task wt(input logic [7:0] v);
      int i;
      for (i = 0; i < 3000 && volume_level !== v; i++) @(posedge clock);
      chk("volume", v, volume_level);
   endtask

   task per(input int e);
      int n;
      n = 0;
      while (carrier_tick !== 1'b1 && n < 300) begin
         @(posedge clock);
         n++;
      end
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (carrier_tick !== 1'b1 && n < 300);
      chk("carrier period", e, n);
   endtask

   // ----------------------------------------
   // Monitor and timeout
   // ----------------------------------------
   always @(posedge clock) begin
      logic [63:0] n;
      if (rd_dph) begin
         n = exp_q.pop_front();
         chk("hrdata", n[63:32], hrdata & n[31:0]);
      end
      rd_dph = hsel && htrans[1] && hready && !hwrite;
      if (vchk) begin
         chk("volume step", 1'b1, 8'(volume_level - vol_p) <= 8'h08 ||
             8'(vol_p - volume_level) <= 8'h08);
      end
      vol_p = volume_level;
      tmo++;
      if (tmo == 30000) begin
         err_count++;
         finish_test();
      end
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      srst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; rd_dph = 1'b0; vchk = 1'b0; seed = 32'h40DB;
      rst_req = 1'b1; sleep_req = 1'b0; pll_on = 1'b1; def_hi = 1'b0;
      mclk_stop = 1'b0; abuse = 1'b0; det = 4'h1;
      cyc(16);
      srst <= 1'b0;
      rst_req <= 1'b0;
      cyc(250);
      rd(`APFC_STAT_OFS, 32'h0, 32'h7);
      cyc(20);
      rd(`APFC_STAT_OFS, 32'h2, 32'h7);
      chk("volume", 8'h00, volume_level);
      vchk <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(`APFC_CTRL_OFS, 32'(i << 1));
         cyc(3);
         chk("ratio", (i == 0) ? `APFC_RATIO_48K : (i == 1) ? `APFC_RATIO_96K :
             `APFC_RATIO_192K, mclk_ratio);
      end
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         wr(`APFC_CTRL_OFS, {16'h0, seed[7:0], 8'h00});
         wt(seed[7:0]);
      end
      wr(`APFC_CTRL_OFS, 32'h4002);
      wt(8'h40);
      for (int p = 0; p < 2; p++) begin
         pll_on <= p[0];
         cyc(6);
         chk("pll", p[0], ctl.pll_enable);
         per(p ? `APFC_DIV_PLL : `APFC_DIV_BYPASS);
      end
      sleep_req <= 1'b1;
      wt(8'h00);
      cyc(6);
      chk("gates", 3'b000, {ctl.power_stage_en, ctl.digital_clk_en,
          ctl.analog_bias_en});
      rd(`APFC_STAT_OFS, 32'h4, 32'h7);
      wr(`APFC_CTRL_OFS, 32'h1000);
      rd(`APFC_CTRL_OFS, 32'h4002, 32'hFF07);
      sleep_req <= 1'b0;
      wt(8'h40);
      cyc(4);
      chk("gates", 3'b111, {ctl.power_stage_en, ctl.digital_clk_en,
          ctl.analog_bias_en});
      sleep_req <= 1'b1;
      for (int i = 0; i < 200 && volume_level > 8'h30; i++) @(posedge clock);
      sleep_req <= 1'b0;
      repeat (40) begin
         @(posedge clock);
         chk("bias", 2'b11, {ctl.analog_bias_en, ctl.digital_clk_en});
      end
      wt(8'h40);
      rd(`APFC_STAT_OFS, 32'h2, 32'h7);
      for (int k = 0; k < 3; k++) begin
         det <= (k == 1) ? 4'h5 : 4'h9;
         cyc(6);
         chk("fault", 2'b10, {fault_oe, ctl.power_stage_en});
         det <= 4'h1;
         cyc(20);
         chk("latched", 1'b1, fault_oe);
         if (k == 0) begin
            wr(`APFC_CTRL_OFS, 32'h4003);
         end else if (k == 1) begin
            sleep_req <= 1'b1;
            cyc(8);
            sleep_req <= 1'b0;
         end else begin
            vchk <= 1'b0;
            def_hi <= 1'b1;
            rst_req <= 1'b1;
            cyc(4);
            rst_req <= 1'b0;
         end
         cyc(6);
         chk("released", 1'b0, fault_oe);
      end
      rd(`APFC_CTRL_OFS, 32'h0, 32'h7);
      wt(8'h8D);
      vchk <= 1'b1;
      det <= 4'h3;
      cyc(6);
      chk("stage", 1'b0, ctl.power_stage_en);
      rd(`APFC_STAT_OFS, 32'h80, 32'h80);
      det <= 4'h1;
      cyc(6);
      chk("stage", 1'b1, ctl.power_stage_en);
      det <= 4'h0;
      cyc(6);
      chk("no driver", 1'b1, fault_oe);
      det <= 4'h1;
      cyc(6);
      chk("no driver", 1'b0, fault_oe);
      abuse <= 1'b1;
      mclk_stop <= 1'b1;
      cyc(40);
      chk("weak low", 1'b1, ctl.out_weak_low);
      mclk_stop <= 1'b0;
      cyc(8);
      chk("clock back", 2'b01, {ctl.out_weak_low, fault_oe});
      wr(`APFC_CTRL_OFS, 32'h8D01);
      cyc(4);
      chk("clock back", 1'b0, fault_oe);
      rd(32'h8, 32'h0, 32'hFFFFFFFF);
      chk("hresp", 1'b0, hresp);
      chk("fault_o", 1'b0, fault_o);
      cyc(4);
      finish_test();
   end
endmodule

//--- verif/apfc_host_model.sv
// Purpose: Host controller model driving the amplifier control pins
// Assumes: Runs on the bench clock; detector levels come from the bench
// Notes:   Stops the master clock only after it requests sleep, unless told to abuse
`timescale 1ns/1ps

module apfc_host_model (
   // Clock
   input  wire logic            clock,
   // Commands from the bench
   input  wire logic            rst_req,
   input  wire logic            sleep_req,
   input  wire logic            pll_on,
   input  wire logic            def_hi,
   input  wire logic            mclk_stop,
   input  wire logic            abuse,
   // Detectors: over_temp, short_circuit, logic_uv, driver_supply_ok
   input  wire logic [3:0]      det,
   // Pins toward the device
   output apfc_pkg::apfc_pins_t pins
);
   logic [3:0] fdiv_q  = 4'h0;
   logic       mck_q   = 1'b0;
   logic       slp_n_q = 1'b1;

   always @(posedge clock) begin
      fdiv_q <= fdiv_q + 4'h1;
      slp_n_q <= !(sleep_req || (mclk_stop && !abuse));
      if (!(mclk_stop && (abuse || !slp_n_q))) begin
         mck_q <= !mck_q;
      end
   end

   assign pins = apfc_pkg::apfc_pins_t'{reset_pin_n: !rst_req,
      sleep_request_pin_n: slp_n_q, pll_select_n: !pll_on,
      default_volume_select: def_hi, frame_clock_in: fdiv_q[3],
      master_clock_in: mck_q, over_temp: det[3], short_circuit: det[2],
      logic_uv: det[1], driver_supply_ok: det[0]};
endmodule

//--- verilog/apfc_ctrl.sv
// Purpose: Operating-state, fade and fault control of a class-D amplifier
// Assumes: clock is the master clock domain; pins are asynchronous
// Notes:   Zero-wait-state AHB-Lite slave, always OKAY
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "apfc_regs.svh"

module apfc_ctrl (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 srst,
   // Device pins and detectors
   input  wire apfc_pkg::apfc_pins_t pins,
   // AHB-Lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [31:0]               hrdata,
   // Power, clock and bias control
   output apfc_pkg::apfc_ctl_t       ctl,
   output logic [7:0]                volume_level,
   output logic                      carrier_tick,
   output logic [10:0]               mclk_ratio,
   // Open-drain fault pin
   output logic                      fault_o,
   output logic                      fault_oe
);

   apfc_pkg::apfc_state_reg_t q;
   apfc_pkg::apfc_state_reg_t d;
   apfc_pkg::apfc_pins_t      p;

   localparam apfc_pkg::apfc_state_reg_t RESET_VAL = '0;
   localparam logic [4:0] STOP_CYC = 5'(`APFC_MCLK_STOP_CYC);
   localparam logic [7:0] RST_LAST = 8'(`APFC_RST_EXIT_CYC - 1);

   assign p = q.s2;

   // ----------------------------------------
   // Volume slew by one step toward a target
   // ----------------------------------------
   function automatic logic [7:0] slew(input logic [7:0] cur, input logic [7:0] tgt);
      logic [7:0] r;
      r = tgt;
      if (cur < tgt) begin
         if (tgt - cur > `APFC_VOL_STEP) begin
            r = cur + `APFC_VOL_STEP;
         end
      end else if (cur - tgt > `APFC_VOL_STEP) begin
         r = cur - `APFC_VOL_STEP;
      end
      return r;
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic       fedge;
      logic       medge;
      logic       cause;
      logic       wr_ok;
      logic       mute_wr;
      logic       clr_ev;
      logic       run;
      logic [7:0] tgt;
      logic [6:0] div_last;
      d        = q;
      fedge    = 1'b0;
      medge    = 1'b0;
      cause    = 1'b0;
      wr_ok    = 1'b0;
      mute_wr  = 1'b0;
      clr_ev   = 1'b0;
      run      = 1'b0;
      tgt      = `APFC_VOL_MUTE;
      div_last = 7'h00;

      // Two-stage pin synchronisers
      d.s1 = pins;
      d.s2 = q.s1;

      fedge    = p.frame_clock_in & ~q.fclk_d;
      medge    = p.master_clock_in ^ q.mclk_d;
      d.fclk_d = p.frame_clock_in;
      d.mclk_d = p.master_clock_in;

      if (medge) begin
         d.stop_cnt = 5'h00;
         d.clk_stop = 1'b0;
      end else if (q.stop_cnt == STOP_CYC) begin
         d.clk_stop = 1'b1;
      end else begin
         d.stop_cnt = q.stop_cnt + 5'h01;
      end

      // writes only outside sleep and reset
      wr_ok   = q.ap_valid & q.ap_write & q.ap_ctrl &
                (q.st != apfc_pkg::ST_SLEEP) & (q.st != apfc_pkg::ST_RESET);
      mute_wr = wr_ok & hwdata[`APFC_CTRL_MUTE];
      if (wr_ok) begin
         d.mute    = hwdata[`APFC_CTRL_MUTE];
         d.fs_sel  = hwdata[`APFC_CTRL_FS_LSB +: 2];
         d.vol_reg = hwdata[`APFC_CTRL_VOL_LSB +: 8];
      end

      clr_ev = ~p.reset_pin_n | ~p.sleep_request_pin_n | mute_wr;
      cause  = p.over_temp | p.short_circuit;
      // latch error, set wins over clear
      if (cause) begin
         d.err_lat = 1'b1;
      end else if (clr_ev) begin
         d.err_lat = 1'b0;
      end
      if (medge & q.clk_stop) begin
         d.clk_err = 1'b1;
      end else if (clr_ev) begin
         d.clk_err = 1'b0;
      end

      // ramp target, muted while fading out
      if (q.mute || q.st == apfc_pkg::ST_FADE_OUT) begin
         tgt = `APFC_VOL_MUTE;
      end else begin
         tgt = q.vol_reg;
      end
      run = (q.st == apfc_pkg::ST_FADE_IN) | (q.st == apfc_pkg::ST_RUN) |
            (q.st == apfc_pkg::ST_FADE_OUT);
      if (run && fedge && !p.logic_uv) begin
         d.vol_cur = slew(q.vol_cur, tgt);
      end

      unique case (q.st)
         apfc_pkg::ST_RESET: begin
            if (q.rst_cnt == RST_LAST) begin
               d.vol_reg = p.default_volume_select ? `APFC_VOL_DEF_HI : `APFC_VOL_MUTE;
               d.st      = p.sleep_request_pin_n ? apfc_pkg::ST_FADE_IN : apfc_pkg::ST_SLEEP;
            end else begin
               d.rst_cnt = q.rst_cnt + 8'h01;
            end
         end
         apfc_pkg::ST_FADE_IN: begin
            if (!p.sleep_request_pin_n) begin
               d.st = apfc_pkg::ST_FADE_OUT;
            end else if (q.vol_cur == tgt) begin
               d.st = apfc_pkg::ST_RUN;
            end
         end
         apfc_pkg::ST_RUN: begin
            if (!p.sleep_request_pin_n) begin
               d.st = apfc_pkg::ST_FADE_OUT;
            end
         end
         apfc_pkg::ST_FADE_OUT: begin
            if (p.sleep_request_pin_n) begin
               d.st = apfc_pkg::ST_FADE_IN;
            end else if (q.vol_cur == `APFC_VOL_MUTE) begin
               d.st = apfc_pkg::ST_SLEEP;
            end
         end
         apfc_pkg::ST_SLEEP: begin
            if (p.sleep_request_pin_n) begin
               d.st = apfc_pkg::ST_FADE_IN;
            end
         end
         default: begin
            d.st = apfc_pkg::ST_RESET;
         end
      endcase

      if (!p.reset_pin_n) begin
         d.st      = apfc_pkg::ST_RESET;
         d.rst_cnt = 8'h00;
         d.mute    = 1'b0;
         d.fs_sel  = `APFC_FS_48K;
         d.vol_reg = `APFC_VOL_MUTE;
         d.vol_cur = `APFC_VOL_MUTE;
      end

      unique case (d.fs_sel)
         `APFC_FS_48K: d.ratio = `APFC_RATIO_48K;
         `APFC_FS_96K: d.ratio = `APFC_RATIO_96K;
         default:      d.ratio = `APFC_RATIO_192K;
      endcase

      div_last = 7'(`APFC_DIV_BYPASS - 1);
      if (!p.pll_select_n) begin
         div_last = 7'(`APFC_DIV_PLL - 1);
      end
      if (q.car_cnt >= div_last) begin
         d.car_cnt  = 7'h00;
         d.car_tick = 1'b1;
      end else begin
         d.car_cnt  = q.car_cnt + 7'h01;
         d.car_tick = 1'b0;
      end

      d.ctl.pll_enable     = ~p.pll_select_n;
      // clocks and bias off in sleep
      d.ctl.digital_clk_en = d.st != apfc_pkg::ST_SLEEP;
      d.ctl.analog_bias_en = d.st != apfc_pkg::ST_SLEEP;
      // stages off while hot or faulted
      d.ctl.power_stage_en = ((d.st == apfc_pkg::ST_FADE_IN) | (d.st == apfc_pkg::ST_RUN) |
                              (d.st == apfc_pkg::ST_FADE_OUT)) &
                             ~p.over_temp & ~d.err_lat & ~p.logic_uv &
                             ~d.clk_stop & ~d.clk_err;
      d.ctl.out_weak_low   = d.clk_stop;
      d.fault_oe = d.err_lat | d.clk_err | (~p.driver_supply_ok & ~p.logic_uv);

      // Address phase: capture and prepare read data
      d.ap_valid = hsel & htrans[1] & hready;
      d.ap_write = hwrite;
      d.ap_ctrl  = haddr == `APFC_CTRL_OFS;
      d.hrdata   = 32'h0000_0000;
      if (hsel && htrans[1] && hready && !hwrite) begin
         if (haddr == `APFC_CTRL_OFS) begin
            d.hrdata[`APFC_CTRL_MUTE]           = d.mute;
            d.hrdata[`APFC_CTRL_FS_LSB +: 2]    = d.fs_sel;
            d.hrdata[`APFC_CTRL_VOL_LSB +: 8]   = d.vol_reg;
         end else if (haddr == `APFC_STAT_OFS) begin
            d.hrdata[`APFC_STAT_ST_LSB +: 3]    = d.st;
            d.hrdata[`APFC_STAT_ERR]            = d.err_lat;
            d.hrdata[`APFC_STAT_CERR]           = d.clk_err;
            d.hrdata[`APFC_STAT_STOP]           = d.clk_stop;
            d.hrdata[`APFC_STAT_UV]             = p.logic_uv;
            d.hrdata[`APFC_STAT_VOL_LSB +: 8]   = d.vol_cur;
         end
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         q <= RESET_VAL;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign hrdata       = q.hrdata;
   assign ctl          = q.ctl;
   assign volume_level = q.vol_cur;
   assign carrier_tick = q.car_tick;
   assign mclk_ratio   = q.ratio;
   assign fault_o      = 1'b0;
   assign fault_oe     = q.fault_oe;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   AST_RST_DEFAULT: assert property (
      !p.reset_pin_n |=> q.st == apfc_pkg::ST_RESET && !q.mute && q.vol_cur == 8'h00)
      else $error("reset pin did not restore defaults");

   AST_RST_EXIT: assert property (
      q.st == apfc_pkg::ST_RESET ##1 q.st != apfc_pkg::ST_RESET |->
      $past(q.rst_cnt) == 8'hFF)
      else $error("reset left on wrong cycle");

   AST_SLEEP_OFF: assert property (
      q.st == apfc_pkg::ST_SLEEP |->
      !q.ctl.power_stage_en && !q.ctl.digital_clk_en && !q.ctl.analog_bias_en)
      else $error("sleep left power, clocks or bias on");

   AST_NO_PROG: assert property (
      (q.ap_valid && q.ap_write && q.st == apfc_pkg::ST_SLEEP && p.reset_pin_n) |=>
      $stable(q.vol_reg) && $stable(q.mute) && $stable(q.fs_sel))
      else $error("register written while asleep");

   AST_SLEEP_KEEP: assert property (
      (q.st == apfc_pkg::ST_FADE_OUT && d.st == apfc_pkg::ST_SLEEP) ##1
      (p.reset_pin_n && q.st == apfc_pkg::ST_SLEEP) [*2] |->
      q.vol_reg == $past(q.vol_reg, 2))
      else $error("registers changed entering sleep");

   AST_ABORT: assert property (
      (q.st == apfc_pkg::ST_FADE_OUT && p.sleep_request_pin_n && p.reset_pin_n) |=>
      q.st == apfc_pkg::ST_FADE_IN && q.ctl.analog_bias_en)
      else $error("fade-out not aborted on release");

   AST_CARRIER: assert property (
      (q.car_tick && $stable(q.ctl.pll_enable) && q.ctl.pll_enable) |->
      $past(q.car_cnt) == 7'h1F)
      else $error("carrier divide wrong with PLL on");

   AST_OT: assert property (
      p.over_temp |=> !q.ctl.power_stage_en)
      else $error("power stage on while over temperature");

   AST_FAULT: assert property (
      p.short_circuit |=> q.fault_oe && q.err_lat)
      else $error("short did not latch fault");

   AST_FAULT_HOLD: assert property (
      (q.err_lat && p.reset_pin_n && p.sleep_request_pin_n && !(q.ap_valid && q.ap_write)) |=>
      q.err_lat && q.fault_oe)
      else $error("error latch released without a release event");

   AST_CLK_ERR: assert property (
      (q.clk_stop && (p.master_clock_in != q.mclk_d)) |=> q.clk_err && q.fault_oe)
      else $error("clock return did not latch fault");

   AST_DEF_VOL: assert property (
      (q.st == apfc_pkg::ST_RESET && q.rst_cnt == 8'hFF && p.reset_pin_n) |=>
      q.vol_reg == ($past(p.default_volume_select) ? 8'h8D : 8'h00))
      else $error("default volume not taken from pin");

   AST_CARRIER_BYP: assert property (
      (q.car_tick && $stable(q.ctl.pll_enable) && !q.ctl.pll_enable) |->
      $past(q.car_cnt) == 7'h7F)
      else $error("carrier divide wrong with PLL bypassed");

   AST_PLL: assert property (
      p.reset_pin_n |=> q.ctl.pll_enable == !$past(p.pll_select_n))
      else $error("PLL enable does not follow select pin");

   AST_UV: assert property (
      (p.logic_uv && p.reset_pin_n) |=> !q.ctl.power_stage_en && $stable(q.vol_cur))
      else $error("undervoltage did not halt");

   AST_STOP: assert property (
      $rose(q.clk_stop) |-> $past(q.stop_cnt) == 5'h14 && q.ctl.out_weak_low)
      else $error("clock stop timing or weak low wrong");

   AST_DRV: assert property (
      (!p.driver_supply_ok && !p.logic_uv) |=> q.fault_oe)
      else $error("fault not held for missing driver supply");

   COV_SLEEP: cover property (q.st == apfc_pkg::ST_FADE_OUT ##[1:1000] q.st == apfc_pkg::ST_SLEEP);
   COV_ABORT: cover property (q.st == apfc_pkg::ST_FADE_OUT ##1 q.st == apfc_pkg::ST_FADE_IN);
   COV_ERR:   cover property ($rose(q.err_lat) ##[1:1000] $fell(q.err_lat));
   COV_CERR:  cover property ($rose(q.clk_err));

endmodule

//--- verilog/apfc_pkg.sv
// Purpose: Types of the amplifier power and fault controller
// Assumes: Nothing beyond the constants header
// Notes:   All state lives in one packed struct
package apfc_pkg;

   typedef enum logic [2:0] {
      ST_RESET    = 3'b000,
      ST_FADE_IN  = 3'b001,
      ST_RUN      = 3'b010,
      ST_FADE_OUT = 3'b011,
      ST_SLEEP    = 3'b100
   } apfc_state_t;

   // Pins and detector levels, all from outside the clock domain
   typedef struct packed {
      logic reset_pin_n;
      logic sleep_request_pin_n;
      logic pll_select_n;
      logic default_volume_select;
      logic frame_clock_in;
      logic master_clock_in;
      logic over_temp;
      logic short_circuit;
      logic logic_uv;
      logic driver_supply_ok;
   } apfc_pins_t;

   typedef struct packed {
      logic power_stage_en;
      logic digital_clk_en;
      logic analog_bias_en;
      logic out_weak_low;
      logic pll_enable;
   } apfc_ctl_t;

   typedef struct packed {
      apfc_pins_t  s1;
      apfc_pins_t  s2;
      logic        fclk_d;
      logic        mclk_d;
      apfc_state_t st;
      logic [7:0]  rst_cnt;
      logic [4:0]  stop_cnt;
      logic        clk_stop;
      logic        clk_err;
      logic        err_lat;
      logic        mute;
      logic [1:0]  fs_sel;
      logic [7:0]  vol_reg;
      logic [7:0]  vol_cur;
      logic [6:0]  car_cnt;
      logic        car_tick;
      logic [10:0] ratio;
      logic        ap_valid;
      logic        ap_write;
      logic        ap_ctrl;
      logic [31:0] hrdata;
      apfc_ctl_t   ctl;
      logic        fault_oe;
   } apfc_state_reg_t;

endpackage

//--- verilog/apfc_regs.svh
// Purpose: Constants of the amplifier power and fault controller
// Assumes: 40 MHz clock stands in for the master clock
// Notes:   Offsets are byte addresses on the AHB-Lite port
`ifndef APFC_REGS_SVH
`define APFC_REGS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define APFC_CTRL_OFS     32'h0000_0000
`define APFC_STAT_OFS     32'h0000_0004
`define APFC_CTRL_MUTE    0
`define APFC_CTRL_FS_LSB  1
`define APFC_CTRL_VOL_LSB 8
`define APFC_STAT_ST_LSB  0
`define APFC_STAT_ERR     4
`define APFC_STAT_CERR    5
`define APFC_STAT_STOP    6
`define APFC_STAT_UV      7
`define APFC_STAT_VOL_LSB 8

// ----------------------------------------
// Volume, timing and clock figures
// ----------------------------------------
`define APFC_VOL_0DB      8'h80
`define APFC_VOL_DEF_HI   8'h8D
`define APFC_VOL_MUTE     8'h00
`define APFC_VOL_STEP     8'h08
`define APFC_RST_EXIT_CYC 256
`define APFC_CLK_NS       25
`define APFC_MCLK_STOP_NS 500
`define APFC_MCLK_STOP_CYC ((`APFC_MCLK_STOP_NS + `APFC_CLK_NS - 1) / `APFC_CLK_NS)
`define APFC_DIV_PLL      32
`define APFC_DIV_BYPASS   128
`define APFC_RATIO_48K    11'h400
`define APFC_RATIO_96K    11'h200
`define APFC_RATIO_192K   11'h100
`define APFC_FS_48K       2'h0
`define APFC_FS_96K       2'h1

`endif
